// >>> src/mmc_pkg.sv
// constants and types for front-panel metering and headphone monitor control
`default_nettype none
package mmc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CW = 26;
  localparam int VU_MS = 300;
  localparam int VU_SHIFT = 3;
  localparam int VU_TICK_CYC = (VU_MS * CYC_PER_MS) >> VU_SHIFT;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int DECAY_MS = 30;
  localparam int DECAY_CYC = DECAY_MS * CYC_PER_MS;
  localparam int GAIN_SHOW_MS = 1000;
  localparam int GAIN_SHOW_CYC = GAIN_SHOW_MS * CYC_PER_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int TONE_MS = 150;
  localparam int TONE_CYC = TONE_MS * CYC_PER_MS;
  localparam int GAP_MS = 100;
  localparam int GAP_CYC = GAP_MS * CYC_PER_MS;
  localparam int TONE_HI_HZ = 440;
  localparam int TONE_LO_HZ = 220;
  localparam int HI_HALF_CYC = CLK_HZ / (2 * TONE_HI_HZ);
  localparam int LO_HALF_CYC = CLK_HZ / (2 * TONE_LO_HZ);
  localparam int NSEG = 21;
  localparam int ZOOM_SEG0 = 0;
  localparam logic signed [7:0] DB_FLOOR = -8'sh3c;
  localparam logic signed [7:0] VU_REF_DB [3] = '{8'sh00, 8'sh04, 8'sh08};
  // normal scale thresholds in dBu, bottom segment first
  localparam logic signed [7:0] SEG_DB [NSEG] = '{
    -8'sh1e, -8'sh18, -8'sh14, -8'sh12, -8'sh10, -8'sh0e, -8'sh0c, -8'sh0a, -8'sh08,
    -8'sh06, -8'sh04, -8'sh02, 8'sh00, 8'sh02, 8'sh04, 8'sh06, 8'sh08, 8'sh0a,
    8'sh0c, 8'sh10, 8'sh14};
  localparam logic signed [15:0] TONE_AMP = 16'sh1000;
  localparam logic [15:0] FILE_RST = 16'h0000;
  localparam logic [15:0] DAY_RST = 16'h0000;
  typedef enum logic [2:0] {BAL_VU, BAL_PEAK, BAL_PEAK_HOLD, BAL_VU_PEAK,
    BAL_VU_PEAK_HOLD} mmc_bal_type;
  localparam mmc_bal_type BAL_DEFAULT = BAL_VU_PEAK_HOLD;
  typedef enum logic [1:0] {REF_0DBU, REF_4DBU, REF_8DBU} mmc_ref_type;
  typedef enum logic [2:0] {HP_STEREO, HP_MONO, HP_LEFT, HP_RIGHT, HP_MS, HP_REC} mmc_hp_type;
  typedef enum logic [1:0] {TR_STOP, TR_PLAY, TR_PAUSE} mmc_tr_type;
  typedef enum logic [1:0] {TS_IDLE, TS_TONE, TS_GAP} mmc_ts_type;
  typedef enum logic [1:0] {ANN_NONE, ANN_TIME, ANN_FILE, ANN_DAY} mmc_ann_type;
  typedef struct packed {
    logic knob_press;
    logic gain_turn;
    logic rew;
    logic ffwd;
    logic batt_chk;
    logic play_down;
    logic rc_press;
    logic rc_left;
    logic rc_right;
  } mmc_pins_type;
  typedef struct packed {logic red; logic green;} mmc_led_type;
  localparam mmc_led_type LED_OFF = '{red: 1'b0, green: 1'b0};
  localparam mmc_led_type LED_GREEN = '{red: 1'b0, green: 1'b1};
  localparam mmc_led_type LED_YELLOW = '{red: 1'b1, green: 1'b1};
  localparam mmc_led_type LED_RED = '{red: 1'b1, green: 1'b0};
  typedef struct packed {logic signed [15:0] l; logic signed [15:0] r;} mmc_stereo_type;
endpackage
`default_nettype wire

// >>> src/mmc_top.sv
// meter ballistics, zoom, activity leds, headphone routing, cue tones, playback transport
`default_nettype none
module mmc_top #(
  parameter int NIN = 5,
  parameter int VU_TICK = mmc_pkg::VU_TICK_CYC,
  parameter int HOLD = mmc_pkg::HOLD_CYC,
  parameter int DECAY = mmc_pkg::DECAY_CYC,
  parameter int GAIN_SHOW = mmc_pkg::GAIN_SHOW_CYC,
  parameter int BLINK = mmc_pkg::BLINK_CYC,
  parameter int TONE = mmc_pkg::TONE_CYC,
  parameter int GAP = mmc_pkg::GAP_CYC,
  parameter int HI_HALF = mmc_pkg::HI_HALF_CYC,
  parameter int LO_HALF = mmc_pkg::LO_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // setup options
  input wire logic cfg_load_i,
  input wire logic factory_i,
  input wire mmc_pkg::mmc_bal_type bal_i,
  input wire mmc_pkg::mmc_ref_type vu_ref_i,
  input wire logic zoom_en_i,
  // front panel switches, asynchronous
  input wire mmc_pkg::mmc_pins_type pins_i,
  input wire logic [4:0] hp_gain_i,
  // levels and input activity
  input wire logic signed [7:0] level_i [2],
  input wire logic [NIN-1:0] act_sig_i,
  input wire logic [NIN-1:0] act_lim_i,
  input wire logic [NIN-1:0] act_over_i,
  input wire logic [NIN-1:0] solo_listen_i,
  input wire logic [NIN-1:0] mute_i,
  // audio and recorder
  input wire mmc_pkg::mmc_hp_type hp_pos_i,
  input wire logic ms_linked_i,
  input wire mmc_pkg::mmc_stereo_type prog_i,
  input wire mmc_pkg::mmc_stereo_type rec_feed_i,
  input wire mmc_pkg::mmc_stereo_type play_audio_i,
  input wire logic rec_active_i,
  input wire logic [15:0] last_file_i,
  // meters and indicators
  output wire logic [1:0][mmc_pkg::NSEG-1:0] meter_o,
  output logic zoom_led_o,
  output var mmc_pkg::mmc_led_type [NIN-1:0] act_led_o,
  // audio out
  output var mmc_pkg::mmc_stereo_type hp_o,
  output var mmc_pkg::mmc_stereo_type out_o,
  // transport
  output var mmc_pkg::mmc_tr_type tr_o,
  output logic rew_shuttle_o,
  output logic ffwd_shuttle_o,
  output logic play_to_out_o,
  output logic [15:0] file_sel_o,
  output logic [15:0] day_sel_o,
  output logic announce_o,
  output var mmc_pkg::mmc_ann_type announce_kind_o
);
  localparam int CW = mmc_pkg::CW;
  localparam int NSEG = mmc_pkg::NSEG;

  function automatic logic [NSEG-1:0] bar(input logic signed [7:0] db, input logic zm);
    logic [NSEG-1:0] b;
    b = '0;
    for (int s = 0; s < NSEG; s++) begin
      b[s] = zm ? (db >= $signed(8'(s - mmc_pkg::ZOOM_SEG0))) : (db >= mmc_pkg::SEG_DB[s]);
    end
    return b;
  endfunction

  function automatic logic [NSEG-1:0] dot(input logic [NSEG-1:0] b);
    return b & ~(b >> 1);
  endfunction

  // first stage feeds only the second
  mmc_pkg::mmc_pins_type sy1, sy2, sy3, ed;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
    end else begin
      sy1 <= pins_i;
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end
  assign ed = sy2 & ~sy3;

  // shared timers and setup
  logic [CW-1:0] vu_cnt, next_vu_cnt, dc_cnt, next_dc_cnt, bl_cnt, next_bl_cnt;
  logic [CW-1:0] gs_cnt, next_gs_cnt;
  logic blink, next_blink, next_zoom, vu_tick, dc_tick;
  mmc_pkg::mmc_bal_type bal, next_bal;
  mmc_pkg::mmc_ref_type vref, next_vref;
  always_comb begin
    vu_tick = vu_cnt == '0;
    dc_tick = dc_cnt == '0;
    next_vu_cnt = vu_tick ? CW'(VU_TICK - 1) : vu_cnt - 1'b1;
    next_dc_cnt = dc_tick ? CW'(DECAY - 1) : dc_cnt - 1'b1;
    next_blink = blink;
    next_bl_cnt = bl_cnt - 1'b1;
    if (bl_cnt == '0) begin
      next_bl_cnt = CW'(BLINK - 1);
      next_blink = ~blink;
    end
    next_gs_cnt = (gs_cnt == '0) ? gs_cnt : gs_cnt - 1'b1;
    if (ed.gain_turn) next_gs_cnt = CW'(GAIN_SHOW);
    next_bal = bal;
    next_vref = vref;
    if (cfg_load_i) begin
      next_bal = bal_i;
      next_vref = vu_ref_i;
    end
    if (factory_i) begin
      next_bal = mmc_pkg::BAL_DEFAULT;
      next_vref = mmc_pkg::REF_0DBU;
    end
    next_zoom = zoom_led_o;
    if (ed.knob_press) next_zoom = ~zoom_led_o;
    if (!zoom_en_i) next_zoom = 1'b0;
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      vu_cnt <= '0;
      dc_cnt <= '0;
      bl_cnt <= '0;
      gs_cnt <= '0;
      blink <= 1'b0;
      bal <= mmc_pkg::BAL_DEFAULT;
      vref <= mmc_pkg::REF_0DBU;
      zoom_led_o <= 1'b0;
    end else begin
      vu_cnt <= next_vu_cnt;
      dc_cnt <= next_dc_cnt;
      bl_cnt <= next_bl_cnt;
      gs_cnt <= next_gs_cnt;
      blink <= next_blink;
      bal <= next_bal;
      vref <= next_vref;
      zoom_led_o <= next_zoom;
    end
  end

  // per-channel ballistics; vu holds 4 fraction bits so slow steps are not lost
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [11:0] vu, next_vu;
    logic signed [12:0] dv;
    logic signed [7:0] pk, next_pk, hd, next_hd, vdb;
    logic [CW-1:0] hc, next_hc;
    logic [NSEG-1:0] seg, next_seg, vbar;
    always_comb begin
      dv = 13'($signed({level_i[c], 4'h0})) - 13'(vu);
      next_vu = vu_tick ? vu + 12'(dv >>> mmc_pkg::VU_SHIFT) : vu;
      vdb = 8'(vu >>> 4) - mmc_pkg::VU_REF_DB[vref];
      next_pk = pk;
      if (level_i[c] > pk) next_pk = level_i[c];
      else if (dc_tick && level_i[c] < pk && pk > mmc_pkg::DB_FLOOR)
        next_pk = pk - 8'sh01;
      next_hd = hd;
      next_hc = (hc == '0) ? hc : hc - 1'b1;
      if (level_i[c] >= hd) begin
        next_hd = level_i[c];
        next_hc = CW'(HOLD - 1);
      end else if (hc == '0) next_hd = pk;
      vbar = bar(vdb, zoom_led_o);
      unique case (bal)
        mmc_pkg::BAL_VU: next_seg = vbar;
        mmc_pkg::BAL_PEAK: next_seg = bar(pk, zoom_led_o);
        mmc_pkg::BAL_PEAK_HOLD: next_seg = bar(pk, zoom_led_o) | dot(bar(hd, zoom_led_o));
        mmc_pkg::BAL_VU_PEAK: next_seg = vbar | dot(bar(pk, zoom_led_o));
        mmc_pkg::BAL_VU_PEAK_HOLD: next_seg = vbar | dot(bar(hd, zoom_led_o));
        default: next_seg = vbar;
      endcase
      if (c == 1 && gs_cnt != '0) next_seg = NSEG'((22'h1 << hp_gain_i) - 22'h1);
    end
    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        vu <= {mmc_pkg::DB_FLOOR, 4'h0};
        pk <= mmc_pkg::DB_FLOOR;
        hd <= mmc_pkg::DB_FLOOR;
        hc <= '0;
        seg <= '0;
      end else begin
        vu <= next_vu;
        pk <= next_pk;
        hd <= next_hd;
        hc <= next_hc;
        seg <= next_seg;
      end
    end
    assign meter_o[c] = seg;
  end

  // activity indicators, later tests take priority
  mmc_pkg::mmc_led_type [NIN-1:0] next_act;
  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      next_act[i] = act_sig_i[i] ? mmc_pkg::LED_GREEN : mmc_pkg::LED_OFF;
      if (act_lim_i[i]) next_act[i] = mmc_pkg::LED_YELLOW;
      if (act_over_i[i]) next_act[i] = mmc_pkg::LED_RED;
      if (solo_listen_i[i]) next_act[i] = blink ? mmc_pkg::LED_YELLOW : mmc_pkg::LED_OFF;
      if (mute_i[i]) next_act[i] = mmc_pkg::LED_RED;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) act_led_o <= '0;
    else act_led_o <= next_act;
  end

  // transport and cue tones
  mmc_pkg::mmc_tr_type next_tr;
  mmc_pkg::mmc_ts_type ts, next_ts;
  mmc_pkg::mmc_ann_type tann, next_tann, req_ann, next_kind;
  logic [15:0] next_file, next_day;
  logic [CW-1:0] tcnt, next_tcnt, pcnt, next_pcnt;
  logic [1:0] tn, next_tn, req_n;
  logic rec_q, thi, next_thi, ph, next_ph, req, req_hi, next_route;
  always_comb begin
    next_tr = tr_o;
    next_route = play_to_out_o;
    next_file = file_sel_o;
    next_day = day_sel_o;
    req = 1'b0;
    req_n = 2'h1;
    req_hi = 1'b0;
    req_ann = mmc_pkg::ANN_NONE;
    unique case (tr_o)
      mmc_pkg::TR_STOP: begin
        if (ed.play_down) begin
          next_tr = mmc_pkg::TR_PLAY;
          next_route = sy2.batt_chk;
          req = 1'b1;
          req_ann = mmc_pkg::ANN_TIME;
        end else if (ed.rew || ed.ffwd) begin
          req = 1'b1;
          req_hi = 1'b1;
          if (sy2.batt_chk) begin
            next_day = ed.rew ? day_sel_o - 1'b1 : day_sel_o + 1'b1;
            req_ann = mmc_pkg::ANN_DAY;
          end else begin
            next_file = ed.rew ? file_sel_o - 1'b1 : file_sel_o + 1'b1;
            req_ann = mmc_pkg::ANN_FILE;
          end
        end
      end
      mmc_pkg::TR_PLAY: if (ed.rc_press) next_tr = mmc_pkg::TR_PAUSE;
      mmc_pkg::TR_PAUSE: begin
        if (ed.rc_press) begin
          next_tr = mmc_pkg::TR_STOP;
          next_route = 1'b0;
        end else if (ed.play_down) next_tr = mmc_pkg::TR_PLAY;
      end
      default: next_tr = mmc_pkg::TR_STOP;
    endcase
    if (!rec_active_i && rec_q) next_file = last_file_i;
    // record cues override any cue in progress
    if (rec_active_i != rec_q) begin
      req = 1'b1;
      req_hi = rec_active_i;
      req_n = rec_active_i ? 2'h1 : 2'h2;
      req_ann = mmc_pkg::ANN_NONE;
    end
    next_ts = ts;
    next_tn = tn;
    next_thi = thi;
    next_tann = tann;
    next_ph = ph;
    next_pcnt = pcnt;
    next_tcnt = (tcnt == '0) ? tcnt : tcnt - 1'b1;
    next_kind = announce_kind_o;
    unique case (ts)
      mmc_pkg::TS_IDLE: next_ph = 1'b0;
      mmc_pkg::TS_TONE: begin
        next_pcnt = pcnt - 1'b1;
        if (pcnt == '0) begin
          next_pcnt = thi ? CW'(HI_HALF - 1) : CW'(LO_HALF - 1);
          next_ph = ~ph;
        end
        if (tcnt == '0) begin
          if (tn > 2'h1) begin
            next_tn = tn - 2'h1;
            next_ts = mmc_pkg::TS_GAP;
            next_tcnt = CW'(GAP - 1);
          end else begin
            next_ts = mmc_pkg::TS_IDLE;
            next_kind = tann;
          end
        end
      end
      mmc_pkg::TS_GAP: begin
        if (tcnt == '0) begin
          next_ts = mmc_pkg::TS_TONE;
          next_tcnt = CW'(TONE - 1);
        end
      end
      default: next_ts = mmc_pkg::TS_IDLE;
    endcase
    if (req) begin
      next_ts = mmc_pkg::TS_TONE;
      next_tn = req_n;
      next_thi = req_hi;
      next_tann = req_ann;
      next_tcnt = CW'(TONE - 1);
      next_pcnt = '0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tr_o <= mmc_pkg::TR_STOP;
      play_to_out_o <= 1'b0;
      file_sel_o <= mmc_pkg::FILE_RST;
      day_sel_o <= mmc_pkg::DAY_RST;
      rec_q <= 1'b0;
      ts <= mmc_pkg::TS_IDLE;
      tn <= '0;
      thi <= 1'b0;
      tann <= mmc_pkg::ANN_NONE;
      ph <= 1'b0;
      pcnt <= '0;
      tcnt <= '0;
      announce_o <= 1'b0;
      announce_kind_o <= mmc_pkg::ANN_NONE;
      rew_shuttle_o <= 1'b0;
      ffwd_shuttle_o <= 1'b0;
    end else begin
      tr_o <= next_tr;
      play_to_out_o <= next_route;
      file_sel_o <= next_file;
      day_sel_o <= next_day;
      rec_q <= rec_active_i;
      ts <= next_ts;
      tn <= next_tn;
      thi <= next_thi;
      tann <= next_tann;
      ph <= next_ph;
      pcnt <= next_pcnt;
      tcnt <= next_tcnt;
      announce_o <= !req && ts == mmc_pkg::TS_TONE && next_ts == mmc_pkg::TS_IDLE
        && tann != mmc_pkg::ANN_NONE;
      announce_kind_o <= next_kind;
      rew_shuttle_o <= tr_o == mmc_pkg::TR_PLAY && sy2.rc_left;
      ffwd_shuttle_o <= tr_o == mmc_pkg::TR_PLAY && sy2.rc_right;
    end
  end

  // headphone and line routing; halving sums trades 6 dB for no clipping
  mmc_pkg::mmc_stereo_type src, mix;
  logic signed [16:0] sum, dif;
  logic signed [15:0] tv;
  always_comb begin
    src = (tr_o != mmc_pkg::TR_STOP) ? play_audio_i : prog_i;
    sum = 17'(src.l) + 17'(src.r);
    dif = 17'(src.l) - 17'(src.r);
    tv = ph ? mmc_pkg::TONE_AMP : -mmc_pkg::TONE_AMP;
    mix = src;
    unique case (hp_pos_i)
      mmc_pkg::HP_STEREO: mix = src;
      mmc_pkg::HP_MONO: mix = '{l: 16'(sum >>> 1), r: 16'(sum >>> 1)};
      mmc_pkg::HP_LEFT: mix = '{l: src.l, r: src.l};
      mmc_pkg::HP_RIGHT: mix = '{l: src.r, r: src.r};
      mmc_pkg::HP_MS: if (!ms_linked_i) mix = '{l: 16'(sum >>> 1), r: 16'(dif >>> 1)};
      mmc_pkg::HP_REC: if (tr_o == mmc_pkg::TR_STOP) mix = rec_feed_i;
      default: mix = src;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hp_o <= '0;
      out_o <= '0;
    end else begin
      hp_o <= (ts == mmc_pkg::TS_TONE) ? mmc_pkg::mmc_stereo_type'{l: tv, r: tv}
        : mix;
      out_o <= play_to_out_o ? play_audio_i : prog_i;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_zoom_toggle;
    (ed.knob_press && zoom_en_i) |=> (zoom_led_o != $past(zoom_led_o));
  endproperty
  a_zoom_toggle: assert property (p_zoom_toggle) else $error("zoom not toggled");
  property p_zoom_off;
    !zoom_en_i |=> !zoom_led_o;
  endproperty
  a_zoom_off: assert property (p_zoom_off) else $error("zoom entered while disabled");
  property p_pk_attack;
    (level_i[0] > g_ch[0].pk) |=> (g_ch[0].pk == $past(level_i[0]));
  endproperty
  a_pk_attack: assert property (p_pk_attack) else $error("peak attack delayed");
  property p_hold_load;
    (level_i[1] >= g_ch[1].hd) |=> (g_ch[1].hc == CW'(HOLD - 1));
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("hold timer not loaded");
  property p_mute_red;
    mute_i[0] |=> (act_led_o[0] == mmc_pkg::LED_RED);
  endproperty
  a_mute_red: assert property (p_mute_red) else $error("muted input not red");
  property p_stereo;
    (hp_pos_i == mmc_pkg::HP_STEREO && ts != mmc_pkg::TS_TONE && tr_o == mmc_pkg::TR_STOP)
      |=> (hp_o == $past(prog_i));
  endproperty
  a_stereo: assert property (p_stereo) else $error("stereo routing wrong");
  sequence s_play_press;
    tr_o == mmc_pkg::TR_PLAY && ed.rc_press;
  endsequence
  sequence s_second_press;
    tr_o == mmc_pkg::TR_PAUSE && ed.rc_press;
  endsequence
  property p_two_press;
    s_play_press ##[1:40] s_second_press |=> (tr_o == mmc_pkg::TR_STOP && !play_to_out_o);
  endproperty
  a_two_press: assert property (p_two_press) else $error("two presses did not stop");
  property p_rec_tone;
    $rose(rec_active_i) |=> (ts == mmc_pkg::TS_TONE && thi && tn == 2'h1);
  endproperty
  a_rec_tone: assert property (p_rec_tone) else $error("record start cue wrong");
  property p_out_prog;
    !play_to_out_o |=> (out_o == $past(prog_i));
  endproperty
  a_out_prog: assert property (p_out_prog) else $error("outputs lost program");
  property p_factory;
    factory_i |=> (bal == mmc_pkg::BAL_DEFAULT);
  endproperty
  a_factory: assert property (p_factory) else $error("factory mode wrong");
endmodule
`default_nettype wire

// >>> tb/mmc_panel.sv
// front panel model: turns one-cycle press requests into held switch levels
`default_nettype none
module mmc_panel (
  // clock
  input wire logic clk_sys_i,
  // requests from the bench
  input wire mmc_pkg::mmc_pins_type press_i,
  input wire logic batt_hold_i,
  // switch levels to the block
  output var mmc_pkg::mmc_pins_type pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt [9] = '{default: 3'h0};
  // a real switch stays closed for several cycles, long enough for the two-stage sync
  always_ff @(posedge clk_sys_i) begin
    for (int b = 0; b < 9; b++) begin
      if (press_i[b]) begin
        cnt[b] <= 3'h4;
      end else if (cnt[b] != 3'h0) begin
        cnt[b] <= cnt[b] - 3'h1;
      end
    end
  end
  always_comb begin
    for (int b = 0; b < 9; b++) begin
      pins_o[b] = (cnt[b] != 3'h0);
    end
    pins_o.batt_chk = batt_hold_i;
  end
endmodule
`default_nettype wire

// >>> tb/mmc_top_bench.sv
// self-checking bench for meters, zoom, activity leds, routing and transport
`default_nettype none
module mmc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic cfg_load = 1'b0;
  logic factory = 1'b0;
  mmc_pkg::mmc_bal_type bal = mmc_pkg::BAL_PEAK;
  mmc_pkg::mmc_ref_type vu_ref = mmc_pkg::REF_0DBU;
  logic zoom_en = 1'b1;
  mmc_pkg::mmc_pins_type press = '0;
  mmc_pkg::mmc_pins_type pins;
  logic batt = 1'b0;
  logic signed [7:0] level [2] = '{8'shc4, 8'shc4};
  logic [4:0] sig = '0, lim = '0, over = '0, solo = '0, mute = '0;
  mmc_pkg::mmc_hp_type hp_pos = mmc_pkg::HP_STEREO;
  logic ms_linked = 1'b0;
  logic rec = 1'b0;
  logic [4:0] hp_gain = '0;
  logic [15:0] last_file = '0;
  mmc_pkg::mmc_stereo_type prog = 32'h01000200, feed = 32'h03000400, play = 32'h0aaa0bbb;
  logic [1:0][20:0] meter;
  logic zoom_led;
  mmc_pkg::mmc_led_type [4:0] act;
  mmc_pkg::mmc_stereo_type hp, out;
  mmc_pkg::mmc_tr_type tr;
  logic play_out;
  logic rew_sh, ffwd_sh, ann;
  int ann_cnt = 0;
  logic [15:0] file_sel, day_sel;
  mmc_pkg::mmc_ann_type kind;
  int miscompares = 0;
  int compares = 0;

  mmc_panel panel (.clk_sys_i(clk_sys_i), .press_i(press), .batt_hold_i(batt), .pins_o(pins));
  // short counts keep the run brief; expectations below follow these values
  mmc_top #(.VU_TICK(4), .HOLD(20), .DECAY(4), .GAIN_SHOW(8), .BLINK(4), .TONE(16),
    .GAP(8), .HI_HALF(2), .LO_HALF(4)) dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .cfg_load_i(cfg_load), .factory_i(factory),
    .bal_i(bal), .vu_ref_i(vu_ref), .zoom_en_i(zoom_en), .pins_i(pins), .hp_gain_i(hp_gain),
    .level_i(level), .act_sig_i(sig), .act_lim_i(lim), .act_over_i(over),
    .solo_listen_i(solo), .mute_i(mute), .hp_pos_i(hp_pos), .ms_linked_i(ms_linked),
    .prog_i(prog), .rec_feed_i(feed), .play_audio_i(play), .rec_active_i(rec),
    .last_file_i(last_file), .meter_o(meter), .zoom_led_o(zoom_led), .act_led_o(act),
    .hp_o(hp), .out_o(out), .tr_o(tr), .rew_shuttle_o(rew_sh), .ffwd_shuttle_o(ffwd_sh),
    .play_to_out_o(play_out), .file_sel_o(file_sel), .day_sel_o(day_sel), .announce_o(ann),
    .announce_kind_o(kind));

  // announce is a one-cycle pulse, so it is counted rather than sampled
  always @(posedge clk_sys_i) ann_cnt <= ann_cnt + int'(ann);

  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ends just after an edge so outputs have settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic push(input mmc_pkg::mmc_pins_type p);
    @(posedge clk_sys_i);
    press <= p;
    @(posedge clk_sys_i);
    press <= '0;
    wait_cyc(8);
  endtask

  task automatic cfgset(input mmc_pkg::mmc_bal_type b, input mmc_pkg::mmc_ref_type r);
    @(posedge clk_sys_i);
    cfg_load <= 1'b1;
    bal <= b;
    vu_ref <= r;
    @(posedge clk_sys_i);
    cfg_load <= 1'b0;
    wait_cyc(3);
  endtask

  task automatic t_peak();
    cfgset(mmc_pkg::BAL_PEAK, mmc_pkg::REF_0DBU);
    @(posedge clk_sys_i);
    level <= '{8'sh0a, 8'sh00};
    wait_cyc(3);
    chk("left peak", 32'(meter[0]), 32'h0003ffff);
    chk("right peak", 32'(meter[1]), 32'h00001fff);
    @(posedge clk_sys_i);
    level <= '{8'shc4, 8'shc4};
    wait_cyc(6);
    chk("slow fall", 32'(meter[0][16]), 32'h1);
    wait_cyc(300);
    chk("fallen", 32'(meter[0]), 32'h0);
  endtask

  task automatic t_hold();
    cfgset(mmc_pkg::BAL_PEAK_HOLD, mmc_pkg::REF_0DBU);
    @(posedge clk_sys_i);
    level <= '{8'sh0a, 8'shc4};
    wait_cyc(4);
    level <= '{8'shc4, 8'shc4};
    wait_cyc(12);
    chk("held", 32'(meter[0][17]), 32'h1);
    wait_cyc(40);
    chk("released", 32'(meter[0][17]), 32'h0);
  endtask

  task automatic t_vu();
    cfgset(mmc_pkg::BAL_VU, mmc_pkg::REF_0DBU);
    @(posedge clk_sys_i);
    level <= '{8'sh0a, 8'shc4};
    wait_cyc(6);
    chk("vu attack", 32'(meter[0][14]), 32'h0);
    wait_cyc(400);
    chk("vu ref 0", 32'(meter[0][14]), 32'h1);
    cfgset(mmc_pkg::BAL_VU, mmc_pkg::REF_4DBU);
    chk("vu ref 4", 32'(meter[0][16:14]), 32'h1);
    cfgset(mmc_pkg::BAL_VU, mmc_pkg::REF_8DBU);
    chk("vu ref 8", 32'({meter[0][14], meter[0][12]}), 32'h1);
    cfgset(mmc_pkg::BAL_VU_PEAK, mmc_pkg::REF_8DBU);
    chk("vu dot", 32'(meter[0][17:14]), 32'h8);
    @(posedge clk_sys_i);
    factory <= 1'b1;
    @(posedge clk_sys_i);
    factory <= 1'b0;
    wait_cyc(3);
    chk("factory", 32'(meter[0][17:16]), 32'h3);
  endtask

  task automatic t_zoom();
    cfgset(mmc_pkg::BAL_PEAK, mmc_pkg::REF_0DBU);
    @(posedge clk_sys_i);
    level <= '{8'sh05, 8'sh19};
    // left peak falls 1 dB per decay step from the earlier 10 dB
    wait_cyc(30);
    push('{knob_press: 1'b1, default: 1'b0});
    chk("zoom on", 32'(zoom_led), 32'h1);
    chk("zoom left", 32'(meter[0]), 32'h0000003f);
    chk("zoom right", 32'(meter[1]), 32'h001fffff);
    push('{knob_press: 1'b1, default: 1'b0});
    chk("zoom off", 32'(zoom_led), 32'h0);
    zoom_en <= 1'b0;
    push('{knob_press: 1'b1, default: 1'b0});
    chk("zoom blocked", 32'(zoom_led), 32'h0);
    zoom_en <= 1'b1;
    hp_gain <= 5'h06;
    push('{gain_turn: 1'b1, default: 1'b0});
    chk("gain bar", 32'(meter[1]), 32'h0000003f);
    wait_cyc(10);
    chk("gain gone", 32'(meter[1]), 32'h001fffff);
  endtask

  task automatic t_act();
    int y = 0;
    int o = 0;
    @(posedge clk_sys_i);
    sig <= 5'h01;
    wait_cyc(2);
    chk("green", 32'(act[0]), 32'(mmc_pkg::LED_GREEN));
    lim <= 5'h01;
    wait_cyc(2);
    chk("yellow", 32'(act[0]), 32'(mmc_pkg::LED_YELLOW));
    over <= 5'h01;
    wait_cyc(2);
    chk("red", 32'(act[0]), 32'(mmc_pkg::LED_RED));
    {lim, over, mute} <= {5'h00, 5'h00, 5'h01};
    wait_cyc(2);
    chk("muted", 32'(act[0]), 32'(mmc_pkg::LED_RED));
    {mute, solo} <= {5'h00, 5'h01};
    wait_cyc(2);
    repeat (16) begin
      y += (act[0] === mmc_pkg::LED_YELLOW);
      o += (act[0] === mmc_pkg::LED_OFF);
      wait_cyc(1);
    end
    chk("solo blink", 32'(y > 0 && o > 0 && y + o == 16), 32'h1);
    {solo, sig} <= '0;
  endtask

  task automatic t_route();
    logic [31:0] rexp [7] = '{32'h01000200, 32'h01800180, 32'h01000100, 32'h02000200,
      32'h0180ff80, 32'h03000400, 32'h01000200};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys_i);
      hp_pos <= mmc_pkg::mmc_hp_type'(3'(i == 6 ? 4 : i));
      ms_linked <= (i == 6);
      wait_cyc(3);
      chk("hp route", hp, rexp[i]);
    end
    hp_pos <= mmc_pkg::HP_STEREO;
  endtask

  task automatic t_transport();
    @(posedge clk_sys_i);
    rec <= 1'b1;
    last_file <= 16'h0005;
    wait_cyc(4);
    chk("start tone", 32'(hp.l == 16'sh1000 || hp.l == -16'sh1000), 32'h1);
    wait_cyc(20);
    rec <= 1'b0;
    wait_cyc(4);
    chk("last file", 32'(file_sel), 32'h5);
    wait_cyc(60);
    push('{rew: 1'b1, default: 1'b0});
    chk("prev file", 32'(file_sel), 32'h4);
    wait_cyc(20);
    chk("file announce", 32'(kind), 32'(mmc_pkg::ANN_FILE));
    batt <= 1'b1;
    wait_cyc(8);
    push('{ffwd: 1'b1, default: 1'b0});
    chk("next day", 32'(day_sel), 32'h1);
    wait_cyc(20);
    chk("day announce", 32'(kind), 32'(mmc_pkg::ANN_DAY));
    push('{play_down: 1'b1, default: 1'b0});
    chk("play", 32'(tr), 32'(mmc_pkg::TR_PLAY));
    chk("to outputs", 32'(play_out), 32'h1);
    chk("out play", out, play);
    batt <= 1'b0;
    wait_cyc(30);
    chk("hp play", hp, play);
    chk("announces", 32'(ann_cnt), 32'h3);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_i);
      press.rc_left <= (k == 0);
      press.rc_right <= (k == 1);
      @(posedge clk_sys_i);
      press <= '0;
      wait_cyc(4);
      chk("shuttle", 32'({rew_sh, ffwd_sh}), (k == 0) ? 32'h2 : 32'h1);
    end
    push('{rc_press: 1'b1, default: 1'b0});
    chk("pause", 32'(tr), 32'(mmc_pkg::TR_PAUSE));
    push('{rc_press: 1'b1, default: 1'b0});
    chk("stop", 32'(tr), 32'(mmc_pkg::TR_STOP));
    chk("out normal", out, prog);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    wait_cyc(4);
    chk("reset meters", 32'(meter[0] | meter[1]), 32'h0);
    chk("reset stop", 32'(tr), 32'(mmc_pkg::TR_STOP));
    t_peak();
    t_hold();
    t_vu();
    t_zoom();
    t_act();
    t_route();
    t_transport();
    print_verdict();
  end

  // whole sequence needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
